// >>> rtl/rofp_consts.svh
// constants for the radio output frame packer
`ifndef ROFP_CONSTS_SVH
`define ROFP_CONSTS_SVH
`define ROFP_ID_BYTE 8'hB7
`define ROFP_STAT_LSB 4
`define ROFP_SEL_W 3
`define ROFP_RAD_W 40
`define ROFP_TAG_W 24
`define ROFP_IQ_W 16
`define ROFP_HDR_ID 9'd0
`define ROFP_HDR_IMSB 9'd1
`define ROFP_HDR_ILSB 9'd2
`define ROFP_HDR_STAT 9'd3
`define ROFP_HDR_QMSB 9'd4
`define ROFP_HDR_LAST 9'd5
`define ROFP_GROUP_END 9'd24
`define ROFP_CHUNK_LAST 9'd507
`define ROFP_FINAL_LAST 9'd503
`define ROFP_RAD_GROUPS 3'd5
`define ROFP_LAST_GROUP 3'd7
`define ROFP_PH_SIDE 2'd0
`define ROFP_PH_MSB 2'd1
`define ROFP_PH_LSB 2'd2
`define ROFP_CHUNKS 4'd10
`define ROFP_LAST_CHUNK 4'd9
`define ROFP_TENTH_US 102400
`define ROFP_CLK_MHZ 125
`endif

// >>> rtl/rofp_pkg.sv
// types shared by the radio output frame packer
package rofp_pkg;
    typedef enum logic [3:0] {
        ROFP_WAIT_PPS = 4'b0001,
        ROFP_IDLE = 4'b0010,
        ROFP_HDR = 4'b0100,
        ROFP_BODY = 4'b1000
    } rofp_state_t;
    typedef logic [7:0] rofp_byte_t;
endpackage

// >>> rtl/rofp_skid.sv
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ns
module rofp_skid #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // rofp_skid

// >>> rtl/rofp_ttag.sv
// free-running time-tag counter, cleared only by reset and by start
`timescale 1ns/1ns
module rofp_ttag #(
    parameter int W = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clear,
    input wire logic step,
    output logic [W-1:0] value
);
    // wraps naturally at 2**W; never cleared at frame boundaries
    always_ff @(posedge mclk) begin
        if (rst || clear) begin
            value <= '0;
        end else if (step) begin
            value <= value + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // rofp_ttag

// >>> rtl/rofp_packer.sv
// radio output frame packer: header, ten chunks, interleaved byte stream
// Functional notes
// - ten time tags per frame, each one above the previous
// - first tag of first frame after start is zero
// - tag counter runs on across frames, never cleared per frame
// - tag is 24-bit unsigned, three bytes, most significant first
// - one tag step per tenth frame period, 102.4 ms; wraps at 2**24
// - tags keep counting until power off or recorder full
// - 1250 I/Q pairs per frame, 16-bit two's complement, two bytes
// - all fields byte aligned; side bytes interleaved among I/Q bytes
// - frame is 5082 bytes, numbered from one
// - identifier at byte 1, status at byte 4
// - header order: ID, I1 hi, I1 lo, status, Q1 hi, Q1 lo
// - radiometry word at byte 7, msb first, stride three bytes
// - each later radiometry word 508 bytes after the previous
// - time tag at byte 22, msb first, stride three bytes
// - each later time tag 508 bytes after the previous
// - after header, ten chunks of 508 bytes each, except the last of 504
// - chunk holds one radiometry, one tag, 125 pairs; last 504 bytes, 124 pairs
// - eight groups of side byte plus I or Q word, then I/Q only
// - I and Q strictly alternate, msb first, filling spare bytes
// - identifier byte is always 0xB7
// - status holds input select in bits 6..4, others zero
// - radiometry is 40-bit accumulator cleared each frame start
`timescale 1ns/1ns
`include "rofp_consts.svh"
module rofp_packer
    import rofp_pkg::*;
#(
    parameter int TENTH_CYCLES = `ROFP_TENTH_US * `ROFP_CLK_MHZ,
    parameter int PWR_W = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic second_pulse_strobe,
    input wire logic recorder_full,
    input wire logic [`ROFP_SEL_W-1:0] input_select,
    input wire logic power_valid,
    input wire logic [PWR_W-1:0] power_value,
    input wire logic iq_valid,
    output logic iq_ready,
    input wire logic [`ROFP_IQ_W-1:0] i_sample,
    input wire logic [`ROFP_IQ_W-1:0] q_sample,
    output logic frame_valid,
    input wire logic frame_ready,
    output logic [7:0] frame_byte,
    output logic running,
    output logic overrun
);
    // ------------------------------------------------------------
    // second pulse synchroniser
    // ------------------------------------------------------------
    logic pps_s1;
    logic pps_s2;
    logic pps_s3;
    logic pps_level;
    logic pps_level_d;
    wire pps_agree = (pps_s2 == pps_s3);
    wire pps_rise = pps_level & ~pps_level_d;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pps_s1 <= 1'b0;
            pps_s2 <= 1'b0;
            pps_s3 <= 1'b0;
            pps_level <= 1'b0;
            pps_level_d <= 1'b0;
        end else begin
            pps_s1 <= second_pulse_strobe;
            pps_s2 <= pps_s1;
            pps_s3 <= pps_s2;
            pps_level <= pps_agree ? pps_s3 : pps_level;
            pps_level_d <= pps_level;
        end
    end

    // ------------------------------------------------------------
    // tenth-period timebase
    // ------------------------------------------------------------
    localparam int TCW = $clog2(TENTH_CYCLES + 1);
    localparam logic [TCW-1:0] TENTH_LAST = TCW'(TENTH_CYCLES - 1);
    logic [TCW-1:0] tenth_cnt;
    logic [3:0] tenth_idx;
    logic started;
    wire start_now = ~started & pps_rise;
    wire tick = running & (tenth_cnt == '0);
    wire frame_start = tick & (tenth_idx == 4'd0);
    wire tenth_wrap = (tenth_cnt == TENTH_LAST);
    wire idx_wrap = (tenth_idx == `ROFP_LAST_CHUNK);

    // start is one-shot; recorder full halts the stream for good
    always_ff @(posedge mclk) begin
        if (rst) begin
            started <= 1'b0;
            running <= 1'b0;
            tenth_cnt <= '0;
            tenth_idx <= 4'd0;
        end else begin
            if (start_now) begin
                started <= 1'b1;
                running <= 1'b1;
                tenth_cnt <= '0;
                tenth_idx <= 4'd0;
            end else if (recorder_full) begin
                running <= 1'b0;
            end else if (running) begin
                tenth_cnt <= tenth_wrap ? '0 : tenth_cnt + TCW'(1);
                if (tick) begin
                    tenth_idx <= idx_wrap ? 4'd0 : tenth_idx + 4'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // time tag and radiometry
    // ------------------------------------------------------------
    logic [`ROFP_TAG_W-1:0] tag_now;
    logic [`ROFP_RAD_W-1:0] rad_acc;
    wire [`ROFP_RAD_W-1:0] pwr_ext = `ROFP_RAD_W'(power_value);

    rofp_ttag #(
        .W(`ROFP_TAG_W)
    ) u_ttag (
        .mclk(mclk),
        .rst(rst),
        .clear(start_now),
        .step(tick),
        .value(tag_now)
    );

    // the value at frame start is the previous frame's total; a power sample on the frame start cycle is lost to the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            rad_acc <= '0;
        end else if (frame_start) begin
            rad_acc <= '0;
        end else if (running & power_valid) begin
            rad_acc <= rad_acc + pwr_ext;
        end
    end

    // ------------------------------------------------------------
    // staging: a tick parks its values until the emitter is free
    // ------------------------------------------------------------
    logic [`ROFP_TAG_W-1:0] stage_tag;
    logic [`ROFP_RAD_W-1:0] stage_rad;
    logic [3:0] stage_chunk;
    logic [`ROFP_SEL_W-1:0] stage_sel;
    logic pending;
    logic [`ROFP_TAG_W-1:0] snap_tag;
    logic [`ROFP_RAD_W-1:0] snap_rad;
    logic [3:0] chunk;
    logic [`ROFP_SEL_W-1:0] status_sel;
    logic take_chunk;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage_tag <= '0;
            stage_rad <= '0;
            stage_chunk <= 4'd0;
            stage_sel <= '0;
            pending <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (tick) begin
                stage_tag <= tag_now;
                stage_rad <= rad_acc;
                stage_chunk <= tenth_idx;
                stage_sel <= frame_start ? input_select : stage_sel;
                pending <= 1'b1;
                overrun <= overrun | (pending & ~take_chunk);
            end else if (take_chunk) begin
                pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            snap_tag <= '0;
            snap_rad <= '0;
            chunk <= 4'd0;
            status_sel <= '0;
        end else if (take_chunk) begin
            snap_tag <= stage_tag;
            snap_rad <= stage_rad;
            chunk <= stage_chunk;
            status_sel <= stage_sel;
        end
    end

    // ------------------------------------------------------------
    // I/Q pair holding register
    // ------------------------------------------------------------
    logic [`ROFP_IQ_W-1:0] pair_i;
    logic [`ROFP_IQ_W-1:0] pair_q;
    logic pair_full;
    logic pair_done;
    assign iq_ready = ~pair_full;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pair_i <= '0;
            pair_q <= '0;
            pair_full <= 1'b0;
        end else if (iq_valid & ~pair_full) begin
            pair_i <= i_sample;
            pair_q <= q_sample;
            pair_full <= 1'b1;
        end else if (pair_done) begin
            pair_full <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // emitter state
    // ------------------------------------------------------------
    rofp_state_t state;
    rofp_state_t next_state;
    logic [8:0] byte_idx;
    logic [1:0] phase;
    logic [2:0] grp;
    logic sel_q;
    logic buf_ready;
    wire in_hdr = (state == ROFP_HDR);
    wire in_body = (state == ROFP_BODY);
    wire in_groups = (byte_idx < `ROFP_GROUP_END);
    wire last_chunk = (chunk == `ROFP_LAST_CHUNK);
    wire [8:0] body_last = last_chunk ? `ROFP_FINAL_LAST : `ROFP_CHUNK_LAST;

    // which kind of byte the current position carries
    wire hdr_id = in_hdr & (byte_idx == `ROFP_HDR_ID);
    wire hdr_stat = in_hdr & (byte_idx == `ROFP_HDR_STAT);
    wire hdr_lsb = in_hdr & ((byte_idx == `ROFP_HDR_ILSB) | (byte_idx == `ROFP_HDR_LAST));
    wire body_side = in_body & in_groups & (phase == `ROFP_PH_SIDE);
    wire body_lsb = in_body & (in_groups ? (phase == `ROFP_PH_LSB) : byte_idx[0]);
    wire is_side = hdr_id | hdr_stat | body_side;
    wire is_lsb = hdr_lsb | body_lsb;
    wire is_iq = (in_hdr | in_body) & ~is_side;
    wire can_emit = (in_hdr | in_body) & buf_ready & (~is_iq | pair_full);
    wire end_hdr = in_hdr & (byte_idx == `ROFP_HDR_LAST);
    wire end_body = in_body & (byte_idx == body_last);

    assign take_chunk = (state == ROFP_IDLE) & pending;
    assign pair_done = can_emit & is_iq & is_lsb & sel_q;

    // ------------------------------------------------------------
    // byte selection
    // ------------------------------------------------------------
    wire [2:0] tag_grp = grp - `ROFP_RAD_GROUPS;
    wire [2:0] rad_rev = 3'd4 - grp;
    wire [1:0] tag_rev = 2'd2 - tag_grp[1:0];
    wire [7:0] rad_byte = snap_rad[{rad_rev, 3'b000} +: 8];
    wire [7:0] tag_byte = snap_tag[{tag_rev, 3'b000} +: 8];
    wire [7:0] status_byte = 8'(status_sel) << `ROFP_STAT_LSB;
    wire [`ROFP_IQ_W-1:0] iq_word = sel_q ? pair_q : pair_i;
    wire [7:0] iq_byte = is_lsb ? iq_word[7:0] : iq_word[15:8];
    wire [7:0] side_byte = (grp < `ROFP_RAD_GROUPS) ? rad_byte : tag_byte;
    wire [7:0] hdr_side = hdr_id ? `ROFP_ID_BYTE : status_byte;
    wire [7:0] emit_byte = is_iq ? iq_byte : (in_hdr ? hdr_side : side_byte);

    // ------------------------------------------------------------
    // state sequencing: header then chunk 0, one chunk per tenth
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ROFP_WAIT_PPS: begin
                if (start_now) begin
                    next_state = ROFP_IDLE;
                end
            end
            ROFP_IDLE: begin
                if (take_chunk) begin
                    next_state = (stage_chunk == 4'd0) ? ROFP_HDR : ROFP_BODY;
                end
            end
            ROFP_HDR: begin
                if (can_emit & end_hdr) begin
                    next_state = ROFP_BODY;
                end
            end
            ROFP_BODY: begin
                if (can_emit & end_body) begin
                    next_state = ROFP_IDLE;
                end
            end
            default: begin
                next_state = ROFP_WAIT_PPS;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ROFP_WAIT_PPS;
        end else begin
            state <= next_state;
        end
    end

    // position counters inside header and chunk
    wire leave = can_emit & (end_hdr | end_body);
    wire [1:0] next_phase = (phase == `ROFP_PH_LSB) ? `ROFP_PH_SIDE : phase + 2'd1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            byte_idx <= 9'd0;
            phase <= `ROFP_PH_SIDE;
            grp <= 3'd0;
        end else if (leave | take_chunk) begin
            byte_idx <= 9'd0;
            phase <= `ROFP_PH_SIDE;
            grp <= 3'd0;
        end else if (can_emit) begin
            byte_idx <= byte_idx + 9'd1;
            if (in_body & in_groups) begin
                phase <= next_phase;
                if (phase == `ROFP_PH_LSB) begin
                    grp <= (grp == `ROFP_LAST_GROUP) ? grp : grp + 3'd1;
                end
            end
        end
    end

    // I/Q alternation runs through the whole frame
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_q <= 1'b0;
        end else if (can_emit & is_iq & is_lsb) begin
            sel_q <= ~sel_q;
        end
    end

    // ------------------------------------------------------------
    // output buffer: stall of the receiver loses no byte
    // ------------------------------------------------------------
    rofp_skid #(
        .W(8)
    ) u_skid (
        .mclk(mclk),
        .rst(rst),
        .in_valid(can_emit),
        .in_ready(buf_ready),
        .in_data(emit_byte),
        .out_valid(frame_valid),
        .out_ready(frame_ready),
        .out_data(frame_byte)
    );
endmodule // rofp_packer

// >>> sim/rofp_packer_checker.sv
// port checker for the radio output frame packer
`timescale 1ns/1ns
module rofp_packer_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic second_pulse_strobe,
    input wire logic recorder_full,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic [7:0] frame_byte,
    input wire logic running
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ---------------------------------------------
    // frame position tracking
    // ---------------------------------------------
    logic [12:0] pos;
    logic [7:0] fcnt;
    logic started;
    wire logic take = frame_valid && frame_ready;
    wire logic [7:0] tag_lo = fcnt * 8'h0A;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pos <= 13'h0000;
            fcnt <= 8'h00;
            started <= 1'b0;
        end else begin
            started <= started | running;
            if (take) begin
                pos <= (pos == 13'd5081) ? 13'h0000 : pos + 13'h0001;
                fcnt <= (pos == 13'd5081) ? fcnt + 8'h01 : fcnt;
            end
        end
    end
    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    sequence start_seen;
        $rose(second_pulse_strobe) && !recorder_full;
    endsequence
    sequence stalled_byte;
        frame_valid && !frame_ready;
    endsequence
    byte_hold_a: assert property (stalled_byte |=> frame_valid && $stable(frame_byte))
        else $error("stalled byte changed or vanished");
    start_run_a: assert property (start_seen |-> ##[3:7] running)
        else $error("start pulse did not start the stream");
    full_stop_a: assert property (recorder_full |=> !running)
        else $error("still running with recorder full");
    stop_cause_a: assert property ($fell(running) |-> $past(recorder_full))
        else $error("stream stopped without recorder full");
    quiet_before_a: assert property (frame_valid |-> started || running)
        else $error("byte offered before start");
    id_first_a: assert property (take && pos == 13'd0 |-> frame_byte == 8'hB7)
        else $error("first frame byte is not the identifier");
    status_pad_a: assert property (take && pos == 13'd3 |-> frame_byte[7] == 1'b0
        && frame_byte[3:0] == 4'h0)
        else $error("status byte has stray bits");
    tag_low_a: assert property (take && pos == 13'd27 |-> frame_byte == tag_lo)
        else $error("first tag of frame is wrong");
endmodule // rofp_packer_checker

// >>> sim/rofp_recorder.sv
// recorder model: takes frame bytes, stalls at random when asked
`timescale 1ns/1ns
module rofp_recorder (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall_en,
    output logic frame_ready
);
    // a byte counts on valid and ready; stalls exercise the buffer
    always_ff @(posedge mclk) begin
        if (rst) begin
            frame_ready <= 1'b0;
        end else begin
            frame_ready <= stall_en ? 1'($urandom_range(0, 1)) : 1'b1;
        end
    end
endmodule // rofp_recorder

// >>> sim/rofp_packer_bench.sv
// self-checking bench for the radio output frame packer
`timescale 1ns/1ns
module rofp_packer_bench;
    import rofp_pkg::*;
    localparam int TENTH = 2000;
    localparam int FLEN = 5082;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic strobe = 1'b0;
    logic full = 1'b0;
    logic [2:0] sel = 3'h5;
    logic pwr_v = 1'b0;
    logic [31:0] pwr = 32'h00000000;
    logic iq_v = 1'b1;
    logic [15:0] i_s = 16'h8000;
    logic [15:0] q_s = 16'h7FFF;
    logic stall_en = 1'b0;
    logic iq_ready, frame_valid, frame_ready, running, overrun;
    logic [7:0] frame_byte;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int nbytes = 0;
    logic [31:0] iq_q[$];
    logic [2:0] sel_f[2];
    logic [39:0] pv = 40'h0000000000;
    // ---------------------------------------------
    // design and partner
    // ---------------------------------------------
    rofp_packer #(.TENTH_CYCLES(TENTH)) dut_u (.mclk(mclk), .rst(rst),
        .second_pulse_strobe(strobe), .recorder_full(full), .input_select(sel),
        .power_valid(pwr_v), .power_value(pwr), .iq_valid(iq_v), .iq_ready(iq_ready),
        .i_sample(i_s), .q_sample(q_s), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .frame_byte(frame_byte), .running(running),
        .overrun(overrun));
    rofp_recorder rec_u (.mclk(mclk), .rst(rst), .stall_en(stall_en),
        .frame_ready(frame_ready));
    always #4 mclk = ~mclk;
    // ---------------------------------------------
    // expected frame contents
    // ---------------------------------------------
    function automatic logic [7:0] exp_byte(int n);
        int f, p, c, o, w;
        logic hi;
        logic [15:0] v;
        logic [39:0] rad;
        logic [23:0] tag;
        f = n / FLEN;
        p = n % FLEN;
        c = (p < 6) ? 0 : (p - 6) / 508;
        o = (p < 6) ? 0 : (p - 6) % 508;
        tag = 24'(10 * f + c);
        // chunk 0 carries the previous frame total, cleared per frame
        rad = (f == 0) ? ((c > 3) ? pv : 40'h0) : ((c == 0) ? pv : 40'h0);
        if (p == 0) return 8'hB7;
        if (p == 3) return {1'b0, sel_f[f], 4'h0};
        if (p < 6) begin
            w = p / 3;
            hi = (p % 3 == 1);
        end else if (o < 24 && o % 3 == 0) begin
            if (o < 15) return 8'(rad >> (32 - 8 * (o / 3)));
            return 8'(tag >> (16 - 8 * (o / 3 - 5)));
        end else if (o < 24) begin
            w = 2 + 250 * c + o / 3;
            hi = (o % 3 == 1);
        end else begin
            w = 10 + 250 * c + (o - 24) / 2;
            hi = ((o - 24) % 2 == 0);
        end
        v = (w % 2 == 1) ? iq_q[f * 1250 + w / 2][15:0] : iq_q[f * 1250 + w / 2][31:16];
        return hi ? v[15:8] : v[7:0];
    endfunction
    task automatic check(logic [7:0] got, logic [7:0] exp, string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_bytes(int n);
        while (nbytes < n) begin
            @(posedge mclk);
            #1;
        end
    endtask
    // ---------------------------------------------
    // pair source, byte monitor, watchdog
    // ---------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (!rst && iq_v && iq_ready) iq_q.push_back({i_s, q_s});
        if (frame_valid && frame_ready) begin
            check(frame_byte, exp_byte(nbytes), "frame byte");
            nbytes++;
        end
        // a pair is held until taken, then replaced
        if (!rst && (!iq_v || iq_ready)) begin
            iq_v <= ($urandom_range(0, 3) != 0);
            i_s <= 16'($urandom);
            q_s <= 16'($urandom);
        end
        if (cycles == 60000) begin
            n_fail++;
            summarize();
        end
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        void'($urandom(32'h5621));
        sel_f[0] = 3'h5;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        // still the reset values: the edge just past sampled rst high
        check({7'h00, iq_ready}, 8'h01, "pair ready in reset");
        @(posedge mclk);
        #1;
        check({7'h00, frame_valid}, 8'h00, "valid after reset");
        check({7'h00, running}, 8'h00, "running after reset");
        // iq_v starts high, so the first pair is taken at the first free edge
        check({7'h00, iq_ready}, 8'h00, "pair taken after release");
        check(frame_byte, 8'h00, "byte after reset");
        $display("test reset done");
        @(posedge mclk);
        strobe <= 1'b1;
        stall_en <= 1'b1;
        repeat (8) @(posedge mclk);
        strobe <= 1'b0;
        #1;
        check({7'h00, running}, 8'h01, "running after strobe");
        wait_bytes(6 + 2 * 508);
        @(posedge mclk);
        sel_f[1] = 3'($urandom);
        sel <= sel_f[1];
        wait_bytes(6 + 4 * 508);
        repeat (300) @(posedge mclk);
        pv = {8'h00, $urandom};
        pwr <= pv[31:0];
        pwr_v <= 1'b1;
        @(posedge mclk);
        pwr_v <= 1'b0;
        wait_bytes(FLEN);
        $display("test first frame done");
        wait_bytes(2 * FLEN);
        $display("test second frame done");
        @(posedge mclk);
        full <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check({7'h00, running}, 8'h00, "running with recorder full");
        repeat (4000) @(posedge mclk);
        check(8'(nbytes - 2 * FLEN), 8'h00, "bytes after stop");
        check({7'h00, overrun}, 8'h00, "overrun flag");
        $display("test recorder full done");
        summarize();
    end
endmodule // rofp_packer_bench
bind rofp_packer rofp_packer_checker chk_u (.mclk(mclk), .rst(rst),
    .second_pulse_strobe(second_pulse_strobe), .recorder_full(recorder_full),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_byte(frame_byte),
    .running(running));
